// ==== logic/id_rom.sv ====
`timescale 1ns/1ps
`include "quad_cfg.svh"

module id_rom #(
   parameter logic [7:0] MAKER_CODE   = 8'h5a, // Arbitrary value
   parameter logic [3:0] PRODUCT_CODE = 4'h9,  // Arbitrary value
   parameter logic [1:0] SILICON_STEP = 2'b00,
   parameter logic [1:0] SENSE_CODE   = 2'b01,
   parameter logic [3:0] FW_MAJOR     = 4'h1,
   parameter logic [3:0] FW_MINOR     = 4'h2
) (
   input  wire logic [7:0] addr,
   output logic            hit,
   output logic [7:0]      data
);

   // Fixed identification values, never written
   always_comb begin
      hit  = 1'b1;
      data = 8'h00;
      unique case (addr)
         `MAKER_OFS:   data = MAKER_CODE;
         `FW_OFS:      data = {FW_MAJOR, FW_MINOR};
         `SILICON_OFS:
            data = {PRODUCT_CODE, SILICON_STEP, SENSE_CODE};
         default:      hit  = 1'b0;
      endcase
   end

endmodule

// ==== logic/port_ctl_if.sv ====
`timescale 1ns/1ps

interface port_ctl_if;
   logic                 port_reinit;
   logic                 power_off;
   logic                 clear_events;
   logic                 power_req;
   logic [3:0]           event_in;
   logic                 police_wr;
   quad_pkg::byte_type   police_wdata;
   logic [3:0]           events;
   logic                 powered;
   quad_pkg::byte_type   police;

   modport ctl (
      output port_reinit, power_off, clear_events, power_req, event_in,
             police_wr, police_wdata,
      input  events, powered, police
   );
   modport slice (
      input  port_reinit, power_off, clear_events, power_req, event_in,
             police_wr, police_wdata,
      output events, powered, police
   );
endinterface

// ==== logic/port_slice.sv ====
`timescale 1ns/1ps
`include "quad_cfg.svh"

module port_slice (
   input wire logic   clk,
   input wire logic   nrst,
   port_ctl_if.slice  ctl
);

   // Sticky events; a new event wins over any clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctl.events <= `EVENT_RST;
      end else if (ctl.port_reinit || ctl.power_off || ctl.clear_events) begin
         ctl.events <= ctl.event_in;
      end else begin
         ctl.events <= ctl.events | ctl.event_in;
      end
   end

   // Power state, dropped by a reinit or accepted power-off
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctl.powered <= 1'b0;
      end else if (ctl.port_reinit || ctl.power_off) begin
         ctl.powered <= 1'b0;
      end else if (ctl.power_req) begin
         ctl.powered <= 1'b1;
      end
   end

   // Policing threshold, back to default on reinit
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctl.police <= `POLICE_RST;
      end else if (ctl.port_reinit || ctl.power_off) begin
         ctl.police <= `POLICE_RST;
      end else if (ctl.police_wr) begin
         ctl.police <= ctl.police_wdata;
      end
   end

endmodule

// ==== logic/quad_cfg.svh ====
`ifndef QUAD_CFG_SVH
`define QUAD_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CMD_OFS        8'h1a
`define MAKER_OFS      8'h1b
`define FW_OFS         8'h41
`define SILICON_OFS    8'h43
`define POWER_OFS      8'h60
`define EVENT_BASE     8'h61
`define POLICE_BASE    8'h65
`define MODE_OFS       8'h69

// ----------------------------------------
// Command bit positions
// ----------------------------------------
`define CLEAR_ALL_BIT  7
`define CLEAR_PIN_BIT  6
`define QUAD_BIT       4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMD_RST        8'h00
`define MODE_RST       8'hff
`define POLICE_RST     8'hff
`define EVENT_RST      4'h0
`define RDATA_RST      8'h00

`endif

// ==== logic/quad_pkg.sv ====
package quad_pkg;

   // Per-port operating mode, two bits per port in the mode register
   typedef enum logic [1:0] {
      MODE_SHUTDOWN,
      MODE_MANUAL,
      MODE_SEMI_AUTO,
      MODE_AUTO
   } port_mode_type;

   typedef logic [7:0] byte_type;

endpackage

// ==== logic/quad_reset_and_id_registers.sv ====
// Function
// - Command bit 7 clears every event in all quads and releases alert pin.
// - Command bit 6 releases the alert pin, events stay as they are.
// - Command bit 4 restores all registers of this quad to defaults.
// - Command bits 3..0 restore port four..one registers to defaults.
// - A port reset turns power off on a powered port.
// - Port reset works in any mode; power-off command depends on mode.
// - Command register is write-only, resets to zero, zero bits do nothing.
// - Maker identity is read-only and fixed for all revisions.
// - Firmware version: major in upper nibble, minor in lower nibble.
// - Silicon version bits 7..4 hold the product code.
// - Silicon version bits 3..2 hold the silicon stepping code.
// - Port reset restores power status, events and policing.
`timescale 1ns/1ps
`include "quad_cfg.svh"

module quad_reset_and_id_registers #(
   parameter logic [7:0] MAKER_CODE   = 8'h5a, // Arbitrary value
   parameter logic [3:0] PRODUCT_CODE = 4'h9,  // Arbitrary value
   parameter logic [1:0] SILICON_STEP = 2'b00,
   parameter logic [1:0] SENSE_CODE   = 2'b01,
   parameter logic [3:0] FW_MAJOR     = 4'h1,
   parameter logic [3:0] FW_MINOR     = 4'h2
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic [15:0] port_event,
   input  wire logic [3:0]  port_power_req,
   input  wire logic [3:0]  port_power_off_cmd,
   output logic      [3:0]  port_power_en,
   output logic      [3:0]  port_reinit_done,
   output logic             clear_all_quads,
   output logic             alert_pin_n
);

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic        cmd_wr;
   logic        clear_every_event;
   logic        clear_pin;
   logic        quad_reinit;
   logic [3:0]  port_reinit;
   logic [3:0]  power_off_ok;
   logic        any_new_event;
   logic [7:0]  mode_reg;
   logic [7:0]  next_rdata;
   logic        rom_hit;
   logic [7:0]  rom_data;
   logic [3:0]  events_q [4];
   logic [7:0]  police_q [4];
   logic [3:0]  powered_q;

   // Command strobes last only the write cycle
   assign cmd_wr            = reg_wr && (reg_addr == `CMD_OFS);
   assign clear_every_event = cmd_wr && reg_wdata[`CLEAR_ALL_BIT];
   assign clear_pin         = cmd_wr && reg_wdata[`CLEAR_PIN_BIT];
   assign quad_reinit       = cmd_wr && reg_wdata[`QUAD_BIT];
   assign any_new_event     = |port_event;

   // ----------------------------------------
   // Per-port slices
   // ----------------------------------------
   port_ctl_if ctl [4] ();

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_port
         quad_pkg::port_mode_type mode;

         assign mode = quad_pkg::port_mode_type'(mode_reg[2*i+1 -: 2]);
         // Reinit ignores mode, power-off only in manual or semi-auto
         assign port_reinit[i]  = quad_reinit
            || (cmd_wr && reg_wdata[i]);
         assign power_off_ok[i] = port_power_off_cmd[i]
                                  && (mode == quad_pkg::MODE_MANUAL
                                  ||  mode == quad_pkg::MODE_SEMI_AUTO);
         assign ctl[i].port_reinit  = port_reinit[i];
         assign ctl[i].power_off    = power_off_ok[i];
         assign ctl[i].clear_events = clear_every_event;
         assign ctl[i].power_req    = port_power_req[i];
         assign ctl[i].event_in     = port_event[4*i+3 -: 4];
         assign ctl[i].police_wr    = reg_wr && reg_addr == `POLICE_BASE
                                      + 8'(i);
         assign ctl[i].police_wdata = reg_wdata;
         assign events_q[i]         = ctl[i].events;
         assign police_q[i]         = ctl[i].police;
         assign powered_q[i]        = ctl[i].powered;

         port_slice u_slice (
            .clk  (clk),
            .nrst (nrst),
            .ctl  (ctl[i])
         );
      end
   endgenerate

   // ----------------------------------------
   // Identification
   // ----------------------------------------
   id_rom #(
      .MAKER_CODE   (MAKER_CODE),
      .PRODUCT_CODE (PRODUCT_CODE),
      .SILICON_STEP (SILICON_STEP),
      .SENSE_CODE   (SENSE_CODE),
      .FW_MAJOR     (FW_MAJOR),
      .FW_MINOR     (FW_MINOR)
   ) u_id (
      .addr (reg_addr),
      .hit  (rom_hit),
      .data (rom_data)
   );

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------

   // Mode register, restored by quad reinit
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mode_reg <= `MODE_RST;
      end else if (quad_reinit) begin
         mode_reg <= `MODE_RST;
      end else if (reg_wr && reg_addr == `MODE_OFS) begin
         mode_reg <= reg_wdata;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------

   // Read mux; command register reads as zero
   always_comb begin
      next_rdata = 8'h00;
      if (rom_hit) begin
         next_rdata = rom_data;
      end else if (reg_addr == `POWER_OFS) begin
         next_rdata = {4'h0, powered_q};
      end else if (reg_addr == `MODE_OFS) begin
         next_rdata = mode_reg;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (reg_addr == `EVENT_BASE + 8'(k)) begin
               next_rdata = {4'h0, events_q[k]};
            end
            if (reg_addr == `POLICE_BASE + 8'(k)) begin
               next_rdata = police_q[k];
            end
         end
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= `RDATA_RST;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------

   // Alert pin, low on any new event; new event beats a clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         alert_pin_n <= 1'b1;
      end else if (any_new_event) begin
         alert_pin_n <= 1'b0;
      end else if (clear_pin || clear_every_event) begin
         alert_pin_n <= 1'b1;
      end
   end

   // Pulse to the other quad for a global event clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         clear_all_quads <= 1'b0;
      end else begin
         clear_all_quads <= clear_every_event;
      end
   end

   // Registered outputs for the port sequencers; enable drops in the reinit or power-off cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         port_power_en    <= 4'h0;
         port_reinit_done <= 4'h0;
      end else begin
         port_power_en    <= powered_q & ~port_reinit
                             & ~power_off_ok;
         port_reinit_done <= port_reinit;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);

   a_clear_all_events: assert property (
      clear_every_event && !any_new_event |=> events_q[0] == 4'h0
      && events_q[1] == 4'h0 && events_q[2] == 4'h0 && events_q[3] == 4'h0)
      else $error("events survive clear-all");

   a_clear_pin_only: assert property (
      clear_pin && !clear_every_event && !any_new_event
      && port_reinit == 4'h0 && power_off_ok == 4'h0
      |=> alert_pin_n && $stable(events_q[0]) && $stable(events_q[2]))
      else $error("pin clear misbehaves");

   a_quad_reset_police: assert property (
      quad_reinit |=> police_q[0] == `POLICE_RST && police_q[3] == `POLICE_RST
      && mode_reg == `MODE_RST && powered_q == 4'h0)
      else $error("quad not restored");

   a_port_reset_one: assert property (
      cmd_wr && reg_wdata[3:0] == 4'h1 && !reg_wdata[`QUAD_BIT]
      && !power_off_ok[1] |=> police_q[0] == `POLICE_RST
      && police_q[1] == $past(police_q[1]))
      else $error("wrong port restored");

   a_reset_powers_off: assert property (
      port_reinit[2] |=> !powered_q[2] ##1 !port_power_en[2])
      else $error("reset port stays powered");

   a_reinit_any_mode: assert property (
      cmd_wr && reg_wdata[1] && mode_reg[3:2] == 2'b00
      |=> !powered_q[1] && port_reinit_done[1])
      else $error("reinit refused in shutdown");

   a_zero_write_idle: assert property (
      cmd_wr && reg_wdata == `CMD_RST |-> port_reinit == 4'h0
      ##1 !clear_all_quads)
      else $error("zero command acted");

   a_cmd_reads_zero: assert property (
      reg_rd && reg_addr == `CMD_OFS |=> reg_rdata == 8'h00)
      else $error("command register readable");

   a_ids_fixed: assert property (
      reg_rd && reg_addr == `SILICON_OFS
      |=> reg_rdata == {PRODUCT_CODE, SILICON_STEP, SENSE_CODE})
      else $error("silicon version wrong");

   a_pulse_once: assert property (
      clear_every_event && !$past(clear_every_event)
      ##1 !clear_every_event |=> !clear_all_quads)
      else $error("command repeated");

endmodule

// ==== sim/host_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Host side of the byte-wide strobe bus
// ----------------------------------------
module host_model (
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // Idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One byte write, taken at the edge after the strobe rises
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d; // Stale data never looks valid
   endtask

   // One byte read, data settles after the following edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
endmodule

// ==== sim/test_quad_reset_and_id_registers.sv ====
`timescale 1ns/1ps
`include "quad_cfg.svh"

`define CHK(what, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         n_fail++; \
         $display("wrong value %s exp %h got %h", what, exp, got); \
      end \
   end

module test_quad_reset_and_id_registers;
   // ----------------------------------------
   // Identity values, all arbitrary
   // ----------------------------------------
   localparam logic [7:0] maker    = 8'h3c;
   localparam logic [3:0] product  = 4'h6;
   localparam logic [1:0] step     = 2'b10;
   localparam logic [1:0] sense    = 2'b11;
   localparam logic [3:0] fw_major = 4'h7;
   localparam logic [3:0] fw_minor = 4'h3;
   localparam int         limit    = 3000;

   logic        clk;
   logic        nrst;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [15:0] port_event;
   logic [3:0]  port_power_req;
   logic [3:0]  port_power_off_cmd;
   logic [3:0]  port_power_en;
   logic [3:0]  port_reinit_done;
   logic        clear_all_quads;
   logic        alert_pin_n;
   int          n_fail = 0;
   int          check_count = 0;
   int          cycles = 0;

   quad_reset_and_id_registers #(
      .MAKER_CODE(maker), .PRODUCT_CODE(product), .SILICON_STEP(step),
      .SENSE_CODE(sense), .FW_MAJOR(fw_major), .FW_MINOR(fw_minor)
   ) DUT (
      .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .port_event(port_event), .port_power_req(port_power_req),
      .port_power_off_cmd(port_power_off_cmd),
      .port_power_en(port_power_en), .port_reinit_done(port_reinit_done),
      .clear_all_quads(clear_all_quads), .alert_pin_n(alert_pin_n)
   );

   host_model host (
      .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
   );

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == limit) begin
         n_fail++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp,
                         input string what);
      logic [7:0] d;
      host.rd(a, d);
      `CHK(what, exp, d)
   endtask

   // Request power on one port, enable shows two edges later
   task automatic power_on(input int p);
      @(posedge clk);
      port_power_req <= 4'h1 << p;
      @(posedge clk);
      port_power_req <= 4'h0;
      repeat (2) @(posedge clk);
      #1 `CHK("power on", 4'h1 << p, port_power_en)
   endtask

   task automatic pulse_off();
      @(posedge clk);
      port_power_off_cmd <= 4'h1;
      @(posedge clk);
      port_power_off_cmd <= 4'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      port_event = 16'h0000;
      port_power_req = 4'h0;
      port_power_off_cmd = 4'h0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      // Identity and reset values
      chk_rd(`MAKER_OFS, maker, "maker");
      chk_rd(`FW_OFS, {fw_major, fw_minor}, "firmware");
      chk_rd(`SILICON_OFS, {product, step, sense}, "silicon");
      chk_rd(`CMD_OFS, `CMD_RST, "command");
      chk_rd(8'hf0, 8'h00, "unmapped");
      host.wr(`MAKER_OFS, 8'h00);
      chk_rd(`MAKER_OFS, maker, "maker kept");
      `CHK("alert idle", 1'b1, alert_pin_n)
      $display("test identity done");
      // Events on every port, then pin clear and full clear
      for (int p = 0; p < 4; p++) begin
         @(posedge clk);
         port_event <= 16'h0001 << (5 * p);
         @(posedge clk);
         port_event <= 16'h0000;
         #1 `CHK("alert set", 1'b0, alert_pin_n)
         chk_rd(`EVENT_BASE + 8'(p), 8'h01 << p, "event");
      end
      host.wr(`CMD_OFS, 8'h00);
      chk_rd(`EVENT_BASE, 8'h01, "zero write");
      host.wr(`CMD_OFS, 8'h40);
      #1 `CHK("pin clear", 1'b1, alert_pin_n)
      `CHK("no broadcast", 1'b0, clear_all_quads)
      chk_rd(`EVENT_BASE + 8'h03, 8'h08, "event kept");
      host.wr(`CMD_OFS, 8'h80);
      #1 `CHK("broadcast", 1'b1, clear_all_quads)
      `CHK("pin after clear", 1'b1, alert_pin_n)
      @(posedge clk);
      #1 `CHK("broadcast ends", 1'b0, clear_all_quads)
      for (int p = 0; p < 4; p++)
         chk_rd(`EVENT_BASE + 8'(p), 8'h00, "event cleared");
      $display("test events done");
      // Port reinit on each powered port
      for (int p = 0; p < 4; p++) begin
         power_on(p);
         chk_rd(`POWER_OFS, 8'h01 << p, "power status");
         host.wr(`POLICE_BASE + 8'(p), 8'h12);
         host.wr(`CMD_OFS, 8'h01 << p);
         #1 `CHK("reinit off", 4'h0, port_power_en)
         `CHK("reinit pulse", 4'h1 << p, port_reinit_done)
         chk_rd(`POLICE_BASE + 8'(p), `POLICE_RST, "police");
         chk_rd(`POWER_OFS, 8'h00, "power cleared");
      end
      $display("test port reinit done");
      // Power-off command depends on mode, reinit does not
      power_on(0);
      pulse_off();
      `CHK("off in auto", 4'h1, port_power_en)
      host.wr(`MODE_OFS, 8'hfd);
      pulse_off();
      `CHK("off in manual", 4'h0, port_power_en)
      // Both ports in shutdown: power-off refused, reinit still acts
      host.wr(`MODE_OFS, 8'hf0);
      power_on(0);
      pulse_off();
      `CHK("off in shutdown", 4'h1, port_power_en)
      host.wr(`CMD_OFS, 8'h03);
      #1 `CHK("reinit shutdown", 4'h0, port_power_en)
      `CHK("reinit shutdown pulse", 4'h3, port_reinit_done)
      $display("test modes done");
      // Whole quad back to defaults
      power_on(1);
      host.wr(`POLICE_BASE, 8'h34);
      host.wr(`CMD_OFS, 8'h10);
      #1 `CHK("quad off", 4'h0, port_power_en)
      `CHK("quad local", 1'b0, clear_all_quads)
      chk_rd(`MODE_OFS, `MODE_RST, "mode");
      chk_rd(`POLICE_BASE, `POLICE_RST, "quad police");
      chk_rd(`POWER_OFS, 8'h00, "quad power");
      $display("test quad reset done");
      summarize();
   end
endmodule
